// *** core/smr_pkg.sv ***
`default_nettype none
package smr_pkg;
  // ---------------------------------------------------------------
  // Parameter register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_STOP_MODE = 16'h0140;
  localparam logic [15:0] ADDR_RSVD_A    = 16'h0142;
  localparam logic [15:0] ADDR_ACCEL     = 16'h0144;
  localparam logic [15:0] ADDR_DECEL     = 16'h0146;
  localparam logic [15:0] ADDR_SMOOTH    = 16'h0148;
  localparam logic [15:0] ADDR_INERTIA   = 16'h014A;
  localparam logic [15:0] ADDR_ZERO_SPD  = 16'h014C;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_STOP_MODE  = 16'h0000;
  localparam logic [15:0] RST_ACCEL      = 16'h00C8;
  localparam logic [15:0] RST_DECEL      = 16'h00C8;
  localparam logic [15:0] RST_SMOOTH     = 16'h0000;
  localparam logic [15:0] RST_INERTIA    = 16'h000A;
  localparam logic [15:0] RST_ZERO_SPD   = 16'h0064;
  // ---------------------------------------------------------------
  // Ranges and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] RAMP_TIME_MIN  = 16'h0001;
  localparam logic [15:0] RAMP_TIME_MAX  = 16'hFFDC;
  localparam logic [15:0] STOP_MODE_MAX  = 16'h0020;
  localparam logic [15:0] ZERO_SPD_MAX   = 16'h07D0;
  localparam logic [15:0] INERTIA_MAX    = 16'h07D0;
  localparam logic [15:0] ANALOG_RAMP_MAX = 16'h4E20;
  localparam logic [15:0] ANALOG_SMTH_MAX = 16'h2710;
  localparam logic [15:0] SMOOTH_OFF     = 16'h0000;
  localparam logic [15:0] SMOOTH_COMP    = 16'h0001;
  localparam logic [15:0] LIMIT_INSTANT  = 16'h0001;
  // ---------------------------------------------------------------
  // Stop mode field
  // ---------------------------------------------------------------
  localparam int          STOP_CODE_LSB  = 0;
  localparam int          STOP_CODE_W    = 4;
  localparam logic [3:0]  STOP_BRAKE     = 4'h0;
  localparam logic [3:0]  STOP_COAST     = 4'h1;
  localparam logic [3:0]  STOP_BRK_COAST = 4'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int TICK_PERIOD_MS = 1;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SMR_RUN   = 2'h0,
    SMR_LIMIT = 2'h1,
    SMR_BRAKE = 2'h3,
    SMR_COAST = 2'h2
  } smr_stop_t;

  // Speed step per tick: rated speed over ramp time, never zero
  function automatic logic [15:0] smr_ramp_step(input logic [15:0] rated, input logic [16:0] ms);
    logic [16:0] q;
    q = (ms == 17'h00000) ? {1'b0, rated} : {1'b0, rated} / ms;
    return (q == 17'h00000) ? 16'h0001 : q[15:0];
  endfunction
endpackage
`default_nettype wire

// *** core/smr_ramp.sv ***
`timescale 1ns/100ps
`default_nettype none
module smr_ramp (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  smr_ramp_if.ramp rif
);
  import smr_pkg::*;
  logic signed [15:0] ref_q;
  logic signed [15:0] ref_d;
  logic signed [16:0] step_s;
  logic signed [16:0] diff;
  logic signed [16:0] up_v;
  logic signed [16:0] dn_v;

  assign step_s = $signed({1'b0, smr_ramp_step(rif.rated, rif.ramp_ms)});
  assign diff   = 17'(rif.target) - 17'(ref_q);
  assign up_v   = 17'(ref_q) + step_s;
  assign dn_v   = 17'(ref_q) - step_s;

  always_comb
  begin
    ref_d = ref_q;
    if (rif.bypass)
      ref_d = rif.target;
    else if (rif.tick && diff > step_s)
      ref_d = up_v[15:0];
    else if (rif.tick && diff < -step_s)
      ref_d = dn_v[15:0];
    else if (rif.tick)
      ref_d = rif.target;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in)
      ref_q <= 16'sh0000;
    else
      ref_q <= ref_d;

  assign rif.spd_ref   = ref_q;
  assign rif.at_target = (diff == 17'sh00000);

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  hold_off_tick_a: assert property (!rif.bypass && !rif.tick |=> $stable(rif.spd_ref))
    else $error("reference moved without a tick");
endmodule
`default_nettype wire

// *** core/smr_ramp_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface smr_ramp_if;
  logic               tick;
  logic        [16:0] ramp_ms;
  logic signed [15:0] target;
  logic signed [15:0] spd_ref;
  logic        [15:0] rated;
  logic               bypass;
  logic               at_target;
  modport tickgen (output tick);
  modport ramp    (input tick, ramp_ms, target, rated, bypass, output spd_ref, at_target);
  modport ctrl    (input tick, spd_ref, at_target, output ramp_ms, target, rated, bypass);
endinterface
`default_nettype wire

// *** core/smr_stop_ramp.sv ***
`timescale 1ns/100ps
`default_nettype none
module smr_stop_ramp #(
  parameter int unsigned TICK_LEN = smr_pkg::TICK_CYCLES
) (
  input  wire logic               core_clk_in,
  input  wire logic               rstn_in,
  input  wire logic        [15:0] param_addr_in,
  input  wire logic        [15:0] param_wdata_in,
  input  wire logic               param_wr_in,
  output logic             [15:0] param_rdata_out,
  input  wire logic               servo_on_in,
  input  wire logic               servo_alarm_in,
  input  wire logic               emergency_stop_input_in,
  input  wire logic               clockwise_limit_in,
  input  wire logic               counterclockwise_limit_in,
  input  wire logic        [15:0] limit_fault_decel_time_in,
  input  wire logic               compensation_config_field_in,
  input  wire logic               analog_source_in,
  input  wire logic        [15:0] rated_speed_in,
  input  wire logic signed [15:0] speed_cmd_in,
  input  wire logic signed [15:0] motor_speed_in,
  output logic signed      [15:0] speed_ref_out,
  output logic                    dyn_brake_out,
  output logic                    drive_enable_out,
  output logic                    zero_speed_flag_out,
  output logic                    track_comp_en_out,
  output logic                    s_curve_active_out,
  output logic                    ramp_bypass_out,
  output smr_pkg::smr_stop_t      stop_state_out
);
  import smr_pkg::*;

  // ---------------------------------------------------------------
  // Parameter registers
  // ---------------------------------------------------------------
  logic [15:0] stop_mode_setting_q;
  logic [15:0] accel_ramp_time_q;
  logic [15:0] decel_ramp_time_q;
  logic [15:0] smoothing_time_field_q;
  logic [15:0] load_inertia_ratio_q;
  logic [15:0] zero_speed_threshold_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        wr_stop;
  logic        wr_acc;
  logic        wr_dec;
  logic        wr_smooth;
  logic        wr_inertia;
  logic        wr_zero;

  function automatic logic ramp_time_ok(input logic [15:0] v);
    return (v >= RAMP_TIME_MIN) && (v <= RAMP_TIME_MAX);
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return param_wr_in && (a == off);
  endfunction

  // Out-of-range writes are dropped
  assign wr_stop    = hit(param_addr_in, ADDR_STOP_MODE) && (param_wdata_in <= STOP_MODE_MAX);
  assign wr_acc     = hit(param_addr_in, ADDR_ACCEL) && ramp_time_ok(param_wdata_in);
  assign wr_dec     = hit(param_addr_in, ADDR_DECEL) && ramp_time_ok(param_wdata_in);
  assign wr_smooth  = hit(param_addr_in, ADDR_SMOOTH) && (param_wdata_in <= RAMP_TIME_MAX);
  assign wr_inertia = hit(param_addr_in, ADDR_INERTIA) && (param_wdata_in <= INERTIA_MAX);
  assign wr_zero    = hit(param_addr_in, ADDR_ZERO_SPD) && (param_wdata_in <= ZERO_SPD_MAX);

  always_ff @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      stop_mode_setting_q    <= RST_STOP_MODE;
      accel_ramp_time_q      <= RST_ACCEL;
      decel_ramp_time_q      <= RST_DECEL;
      smoothing_time_field_q <= RST_SMOOTH;
      load_inertia_ratio_q   <= RST_INERTIA;
      zero_speed_threshold_q <= RST_ZERO_SPD;
    end
    else
    begin
      if (wr_stop)    stop_mode_setting_q    <= param_wdata_in;
      if (wr_acc)     accel_ramp_time_q      <= param_wdata_in;
      if (wr_dec)     decel_ramp_time_q      <= param_wdata_in;
      if (wr_smooth)  smoothing_time_field_q <= param_wdata_in;
      if (wr_inertia) load_inertia_ratio_q   <= param_wdata_in;
      if (wr_zero)    zero_speed_threshold_q <= param_wdata_in;
    end

  // ---------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------
  assign rdata_d = (param_addr_in == ADDR_STOP_MODE) ? stop_mode_setting_q    :
                   (param_addr_in == ADDR_ACCEL)     ? accel_ramp_time_q      :
                   (param_addr_in == ADDR_DECEL)     ? decel_ramp_time_q      :
                   (param_addr_in == ADDR_SMOOTH)    ? smoothing_time_field_q :
                   (param_addr_in == ADDR_INERTIA)   ? load_inertia_ratio_q   :
                   (param_addr_in == ADDR_ZERO_SPD)  ? zero_speed_threshold_q : 16'h0000;

  always_ff @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d;

  assign param_rdata_out = rdata_q;

  // ---------------------------------------------------------------
  // Zero-speed detect
  // ---------------------------------------------------------------
  logic [15:0] speed_mag;
  logic        zero_now;
  logic        zero_q;

  assign speed_mag = motor_speed_in[15] ? 16'(-motor_speed_in) : motor_speed_in;
  assign zero_now  = (speed_mag <= zero_speed_threshold_q);

  always_ff @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in)
      zero_q <= 1'b0;
    else
      zero_q <= zero_now;

  assign zero_speed_flag_out = zero_q;

  // ---------------------------------------------------------------
  // Effective ramp times
  // ---------------------------------------------------------------
  logic [15:0] eff_acc;
  logic [15:0] eff_dec;
  logic [15:0] eff_smooth;
  logic        smooth_on;
  logic        analog_bypass;
  logic        comp_d;

  assign eff_acc    = (analog_source_in && accel_ramp_time_q > ANALOG_RAMP_MAX) ?
                      ANALOG_RAMP_MAX : accel_ramp_time_q;
  assign eff_dec    = (analog_source_in && decel_ramp_time_q > ANALOG_RAMP_MAX) ?
                      ANALOG_RAMP_MAX : decel_ramp_time_q;
  assign eff_smooth = (analog_source_in && smoothing_time_field_q > ANALOG_SMTH_MAX) ?
                      ANALOG_SMTH_MAX : smoothing_time_field_q;
  assign smooth_on  = (eff_smooth > SMOOTH_COMP);
  assign analog_bypass = analog_source_in && (smoothing_time_field_q == SMOOTH_OFF);
  assign comp_d     = (smoothing_time_field_q == SMOOTH_OFF)  ? 1'b0 :
                      (smoothing_time_field_q == SMOOTH_COMP) ? 1'b1 :
                      compensation_config_field_in;

  // ---------------------------------------------------------------
  // Stop sequencer
  // ---------------------------------------------------------------
  smr_stop_t   state_q;
  smr_stop_t   state_d;
  smr_stop_t   stop_entry;
  logic [3:0]  stop_code;
  logic        stop_req;
  logic        limit_fault;

  assign stop_code   = stop_mode_setting_q[STOP_CODE_LSB +: STOP_CODE_W];
  assign stop_req    = !servo_on_in || servo_alarm_in || emergency_stop_input_in;
  assign limit_fault = clockwise_limit_in || counterclockwise_limit_in;
  assign stop_entry  = (stop_code == STOP_COAST) ? SMR_COAST : SMR_BRAKE;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SMR_RUN:
        if (stop_req)
          state_d = stop_entry;
        else if (limit_fault)
          state_d = SMR_LIMIT;
      SMR_LIMIT:
        if (stop_req)
          state_d = stop_entry;
        else if (!limit_fault)
          state_d = SMR_RUN;
      SMR_BRAKE:
        if (!stop_req)
          state_d = SMR_RUN;
        else if (stop_code == STOP_BRK_COAST && zero_q)
          state_d = SMR_COAST;
      SMR_COAST:
        if (!stop_req)
          state_d = SMR_RUN;
      default:
        state_d = SMR_BRAKE;
    endcase
  end

  logic brake_q;
  logic drive_q;
  logic comp_q;

  always_ff @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      state_q <= SMR_BRAKE;
      brake_q <= 1'b1;
      drive_q <= 1'b0;
      comp_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      brake_q <= (state_d == SMR_BRAKE);
      drive_q <= (state_d == SMR_RUN) || (state_d == SMR_LIMIT);
      comp_q  <= comp_d;
    end

  assign dyn_brake_out     = brake_q;
  assign drive_enable_out  = drive_q;
  assign track_comp_en_out = comp_q;
  assign stop_state_out    = state_q;

  // ---------------------------------------------------------------
  // Ramp control
  // ---------------------------------------------------------------
  smr_ramp_if rif ();

  logic        accelerating;
  logic        limit_instant;
  logic        in_limit;
  logic [15:0] base_ms;
  logic [15:0] add_ms;
  logic [16:0] total_ms;

  assign in_limit      = (state_q == SMR_LIMIT);
  assign limit_instant = in_limit && (limit_fault_decel_time_in <= LIMIT_INSTANT);
  assign accelerating  = (rif.spd_ref >= 16'sh0000 && rif.target > rif.spd_ref) ||
                         (rif.spd_ref <= 16'sh0000 && rif.target < rif.spd_ref);
  assign base_ms  = in_limit     ? limit_fault_decel_time_in :
                    accelerating ? eff_acc : eff_dec;
  assign add_ms   = (smooth_on && !in_limit) ? eff_smooth : 16'h0000;
  assign total_ms = {1'b0, base_ms} + {1'b0, add_ms};

  assign rif.ramp_ms = total_ms;
  assign rif.rated   = rated_speed_in;
  assign rif.target  = (state_q == SMR_RUN) ? speed_cmd_in : 16'sh0000;
  assign rif.bypass  = (state_q == SMR_BRAKE) || (state_q == SMR_COAST) ||
                       limit_instant || analog_bypass;

  smr_tick_gen #(
    .TICK_LEN (TICK_LEN)
  ) u_tick (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .rif         (rif.tickgen)
  );

  smr_ramp u_ramp (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .rif         (rif.ramp)
  );

  assign speed_ref_out      = rif.spd_ref;
  assign s_curve_active_out = smooth_on;
  assign ramp_bypass_out    = rif.bypass;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  brake_on_stop_a: assert property (
    state_q == SMR_RUN && stop_req && stop_code == STOP_BRAKE |=> dyn_brake_out && !drive_enable_out)
    else $error("brake not applied on stop code 0");
  coast_on_stop_a: assert property (
    state_q == SMR_RUN && stop_req && stop_code == STOP_COAST |=> !dyn_brake_out && !drive_enable_out)
    else $error("drive or brake active on coast stop");
  brake_release_a: assert property (
    state_q == SMR_BRAKE && stop_req && stop_code == STOP_BRK_COAST && zero_q
    |=> state_q == SMR_COAST ##1 !dyn_brake_out)
    else $error("brake not released at zero speed");
  limit_instant_a: assert property (
    state_q == SMR_LIMIT && limit_fault_decel_time_in == LIMIT_INSTANT |=> speed_ref_out == 16'sh0000)
    else $error("limit stop not instant");
  accel_clamp_a: assert property (
    analog_source_in && accel_ramp_time_q > ANALOG_RAMP_MAX |-> eff_acc == ANALOG_RAMP_MAX)
    else $error("analog accel time not capped");
  decel_clamp_a: assert property (
    analog_source_in && decel_ramp_time_q > ANALOG_RAMP_MAX |-> eff_dec == ANALOG_RAMP_MAX)
    else $error("analog decel time not capped");
  smooth_clamp_a: assert property (
    analog_source_in && smoothing_time_field_q > ANALOG_SMTH_MAX |-> eff_smooth == ANALOG_SMTH_MAX)
    else $error("analog smoothing time not capped");
  analog_bypass_a: assert property (
    analog_source_in && smoothing_time_field_q == SMOOTH_OFF && state_q == SMR_RUN && state_d == SMR_RUN
    |=> speed_ref_out == $past(speed_cmd_in))
    else $error("analog ramp not bypassed");
  total_time_a: assert property (
    state_q == SMR_RUN && accelerating && smooth_on |-> rif.ramp_ms == 17'(eff_acc) + 17'(eff_smooth))
    else $error("accel duration wrong");
  comp_select_a: assert property (
    ##1 $stable(smoothing_time_field_q) && smoothing_time_field_q <= SMOOTH_COMP
    |-> track_comp_en_out == smoothing_time_field_q[0])
    else $error("tracking compensation wrong");
  zero_flag_a: assert property (
    speed_mag <= zero_speed_threshold_q |=> zero_speed_flag_out)
    else $error("zero speed flag missing");
  accel_range_a: assert property (
    param_wr_in && param_addr_in == ADDR_ACCEL && param_wdata_in == 16'h0000 |=> $stable(accel_ramp_time_q))
    else $error("zero accel time accepted");
  decel_range_a: assert property (
    param_wr_in && param_addr_in == ADDR_DECEL && param_wdata_in > RAMP_TIME_MAX |=> $stable(decel_ramp_time_q))
    else $error("oversized decel time accepted");
  decel_total_a: assert property (
    state_q == SMR_RUN && !accelerating && smooth_on |-> rif.ramp_ms == 17'(eff_dec) + 17'(eff_smooth))
    else $error("decel duration wrong");
  smooth_off_a: assert property (
    smoothing_time_field_q <= SMOOTH_COMP |-> !s_curve_active_out)
    else $error("smoothing active at 0 or 1");
  limit_enter_a: assert property (
    state_q == SMR_RUN && !stop_req && limit_fault |=> state_q == SMR_LIMIT && drive_enable_out)
    else $error("limit fault not entered");

  brake_coast_c: cover property (state_q == SMR_BRAKE ##1 state_q == SMR_COAST);
  limit_stop_c:  cover property (state_q == SMR_LIMIT ##1 state_q == SMR_RUN);
  ramp_done_c:   cover property (rif.tick && !rif.bypass ##1 rif.at_target && speed_ref_out != 16'sh0000);
  smooth_on_c:   cover property (state_q == SMR_RUN && smooth_on && rif.tick);
  analog_byp_c:  cover property (state_q == SMR_RUN && analog_bypass && speed_ref_out != 16'sh0000);
endmodule
`default_nettype wire

// *** core/smr_tick_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
module smr_tick_gen #(
  parameter int unsigned TICK_LEN = smr_pkg::TICK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  smr_ramp_if.tickgen rif
);
  import smr_pkg::*;
  logic [31:0] cnt_q;
  logic        wrap;

  assign wrap     = (cnt_q == 32'(TICK_LEN - 1));
  assign rif.tick = wrap;

  always_ff @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in)
      cnt_q <= 32'h00000000;
    else
      cnt_q <= wrap ? 32'h00000000 : cnt_q + 32'h00000001;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  tick_single_a: assert property (rif.tick |=> !rif.tick)
    else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// *** test/smr_motor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module smr_motor_model #(
  parameter int BRAKE_SHIFT = 2,
  parameter int COAST_SHIFT = 5
) (
  input  wire logic               clk_in,
  input  wire logic               rstn_in,
  input  wire logic               drive_in,
  input  wire logic               brake_in,
  input  wire logic signed [15:0] ref_in,
  output logic signed      [15:0] speed_out
);
  // Driven: follows reference; braked: fast decay; free: slow decay
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      speed_out <= 16'sh0000;
    else if (drive_in)
      speed_out <= ref_in;
    else if (brake_in)
      speed_out <= speed_out - (speed_out >>> BRAKE_SHIFT);
    else
      speed_out <= speed_out - (speed_out >>> COAST_SHIFT);
endmodule
`default_nettype wire

// *** test/tb_smr_stop_ramp.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_smr_stop_ramp;
  import smr_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, son = 1'b0, alarm = 1'b0;
  logic estop = 1'b0, cw_lim = 1'b0, ccw_lim = 1'b0, comp = 1'b0, analog = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rated = 16'h03E8, rdata, lim_t = 16'h0001;
  logic signed [15:0] cmd = 16'sh0000, sref, mspd;
  logic brk, drv, zf, tc, sa, byp;
  smr_stop_t st;
  int num_errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  smr_stop_ramp #(.TICK_LEN(20)) u_dut (
    .core_clk_in(clk), .rstn_in(rstn), .param_addr_in(addr),
    .param_wdata_in(wdata), .param_wr_in(wr), .param_rdata_out(rdata),
    .servo_on_in(son), .servo_alarm_in(alarm), .emergency_stop_input_in(estop),
    .clockwise_limit_in(cw_lim), .counterclockwise_limit_in(ccw_lim),
    .limit_fault_decel_time_in(lim_t), .compensation_config_field_in(comp),
    .analog_source_in(analog), .rated_speed_in(rated), .speed_cmd_in(cmd),
    .motor_speed_in(mspd), .speed_ref_out(sref), .dyn_brake_out(brk),
    .drive_enable_out(drv), .zero_speed_flag_out(zf), .track_comp_en_out(tc),
    .s_curve_active_out(sa), .ramp_bypass_out(byp), .stop_state_out(st)
  );
  smr_motor_model u_motor (
    .clk_in(clk), .rstn_in(rstn), .drive_in(drv), .brake_in(brk),
    .ref_in(sref), .speed_out(mspd)
  );
  task automatic stop_test;
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    chk(rdata, e);
  endtask
  // Bounded wait for the reference to reach, or leave, a value
  task automatic wref(input logic [15:0] v, input logic eq);
    int n;
    n = 0;
    while (((sref === v) != eq) && n < 8000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 8000)
    begin
      num_errors++;
      $display("[ERR] %0t reference wait timed out", $time);
    end
  endtask
  task automatic t_regs;
    rchk(ADDR_ACCEL, 16'h00C8);
    rchk(ADDR_DECEL, 16'h00C8);
    rchk(ADDR_SMOOTH, 16'h0000);
    wreg(ADDR_ACCEL, 16'h0000);
    rchk(ADDR_ACCEL, 16'h00C8);
    wreg(ADDR_SMOOTH, 16'hFFDD);
    rchk(ADDR_SMOOTH, 16'h0000);
    wreg(ADDR_DECEL, 16'hFFDC);
    rchk(ADDR_DECEL, 16'hFFDC);
    wreg(ADDR_DECEL, 16'hFFDD);
    rchk(ADDR_DECEL, 16'hFFDC);
    wreg(ADDR_RSVD_A, 16'h1234);
    rchk(ADDR_RSVD_A, 16'h0000);
  endtask
  // Stop code c with cause c: servo off, alarm, emergency stop
  task automatic t_stop;
    wreg(ADDR_ACCEL, 16'h0001);
    for (int c = 0; c < 3; c++)
    begin
      wreg(ADDR_STOP_MODE, 16'(c));
      son = 1'b1;
      cmd = 16'sh03E8;
      wref(16'h03E8, 1'b1);
      repeat (2) @(negedge clk);
      chk({11'h0, zf, st, brk, drv}, 16'h0001);
      son = (c != 0);
      alarm = (c == 1);
      estop = (c == 2);
      repeat (2) @(negedge clk);
      chk({11'h0, zf, st, brk, drv}, (c == 1) ? 16'h0008 : 16'h000E);
      repeat (60) @(negedge clk);
      if (c == 2)
        chk({11'h0, zf, st, brk, drv}, 16'h0018);
      son = 1'b1;
      alarm = 1'b0;
      estop = 1'b0;
    end
  endtask
  task automatic t_limit;
    for (int k = 0; k < 3; k++)
    begin
      wref(16'h03E8, 1'b1);
      lim_t = (k == 2) ? 16'h000A : 16'h0001;
      cw_lim = (k != 1);
      ccw_lim = (k == 1);
      if (k == 2)
      begin
        wref(16'h03E8, 1'b0);
        chk({st, sref[13:0]}, {SMR_LIMIT, 14'h0384});
      end
      else
      begin
        repeat (25) @(negedge clk);
        chk({st, sref[13:0]}, {SMR_LIMIT, 14'h0000});
      end
      cw_lim = 1'b0;
      ccw_lim = 1'b0;
    end
  endtask
  task automatic t_ramp(input logic [15:0] sm, input logic [15:0] ac, input logic [15:0] dc,
                        input logic [15:0] up, input logic [15:0] dn, input logic [1:0] fl);
    wreg(ADDR_DECEL, dc);
    wreg(ADDR_ACCEL, ac);
    wreg(ADDR_SMOOTH, sm);
    cmd = 16'sh0000;
    wref(16'h0000, 1'b1);
    chk({14'h0, sa, tc}, {14'h0, fl});
    cmd = 16'sh03E8;
    wref(16'h0000, 1'b0);
    chk(sref, up);
    wref(16'h03E8, 1'b1);
    cmd = 16'sh0000;
    wref(16'h03E8, 1'b0);
    chk(sref, 16'h03E8 - dn);
  endtask
  task automatic t_bypass;
    wreg(ADDR_SMOOTH, 16'h0000);
    cmd = 16'sh01F4;
    repeat (3) @(negedge clk);
    chk({byp, sref[14:0]}, 16'h81F4);
  endtask
  initial
  begin
    #2000000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_stop();
    t_limit();
    t_ramp(16'h0000, 16'h000A, 16'h0004, 16'h0064, 16'h00FA, 2'b00);
    t_ramp(16'h0001, 16'h000A, 16'h0004, 16'h0064, 16'h00FA, 2'b01);
    comp = 1'b1;
    t_ramp(16'h000A, 16'h000A, 16'h0004, 16'h0032, 16'h0047, 2'b11);
    comp = 1'b0;
    rated = 16'hEA60;
    analog = 1'b1;
    t_ramp(16'h0001, 16'h7530, 16'h7530, 16'h0003, 16'h0003, 2'b01);
    t_ramp(16'h3A98, 16'h0001, 16'h0001, 16'h0005, 16'h0005, 2'b10);
    t_bypass();
    stop_test();
  end
endmodule
`default_nettype wire
